// file: hw/nv_rtc_pkg.sv
`default_nettype none
package nv_rtc_pkg;
  // ==========================================================
  // Geometry
  localparam int ADDR_W = 13;
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 8192;
  localparam logic [12:0] CLK_REG_BASE = 13'h1FF8;
  // Clock register indices (address minus base)
  localparam logic [2:0] IDX_CENTURY = 3'h0;
  localparam logic [2:0] IDX_SECONDS = 3'h1;
  localparam logic [2:0] IDX_DAY = 3'h4;
  // Control and status bit positions
  localparam int WRITE_BIT = 7;
  localparam int READ_BIT = 6;
  localparam int CRYSTAL_HALT_BIT = 7;
  localparam int FREQ_TEST_BIT = 6;
  localparam int BATT_LOW_BIT = 7;
  // ==========================================================
  // Timing
  localparam int CLK_HZ = 50_000_000;
  localparam int SECOND_US = 1_000_000;
  localparam int TICK_CYCLES = SECOND_US / 1_000_000 * CLK_HZ;
  localparam int RECOVERY_DELAY_US = 200;
  localparam int RECOVERY_CYCLES = RECOVERY_DELAY_US * (CLK_HZ / 1_000_000);
  localparam int READ_HALT_MIN_US = 500;
  localparam int READ_HALT_MIN_CYCLES =
    READ_HALT_MIN_US * (CLK_HZ / 1_000_000);
  // ==========================================================
  // Types
  typedef struct packed {
    logic [7:0] year;
    logic [7:0] month;
    logic [7:0] date;
    logic [7:0] day;
    logic [7:0] hours;
    logic [7:0] minutes;
    logic [7:0] seconds;
    logic [7:0] century;
  } cal_t;

  typedef struct packed {
    logic sel_b;
    logic sec_sel;
    logic oe_b;
    logic we_b;
    logic [12:0] addr;
    logic [7:0] data;
  } bus_pins_t;

  typedef enum logic [1:0] {PWR_DOWN, PWR_RECOVER, PWR_UP} pwr_state_t;
  // ==========================================================
  // Values after reset
  localparam cal_t CAL_RESET = '{year: 8'h00, month: 8'h01, date: 8'h01,
    day: 8'h01, hours: 8'h00, minutes: 8'h00, seconds: 8'h00,
    century: 8'h20};
  localparam bus_pins_t BUS_IDLE = '{sel_b: 1'b1, sec_sel: 1'b0,
    oe_b: 1'b1, we_b: 1'b1, addr: 13'h0000, data: 8'h00};
  localparam logic [1:0] STATUS_RESET = 2'h0;
endpackage : nv_rtc_pkg
`default_nettype wire

// file: hw/pin_sync.sv
`default_nettype none
// Three-stage input synchroniser; a bit changes once stages two and
// three agree, so a glitch held for a single sample never counts.
module pin_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_reg;
  logic [W-1:0] s2_reg;
  logic [W-1:0] s3_reg;
  logic [W-1:0] q_next;

  assign q_next = (~(s2_reg ^ s3_reg) & s3_reg) | ((s2_reg ^ s3_reg) & q_o);

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      s1_reg <= INIT;
      s2_reg <= INIT;
      s3_reg <= INIT;
      q_o <= INIT;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_o <= q_next;
    end
  end
endmodule // pin_sync
`default_nettype wire

// file: hw/nv_timekeeping_sram.sv
`default_nettype none
module nv_timekeeping_sram #(
  parameter int TICK_CYCLES = nv_rtc_pkg::TICK_CYCLES,
  parameter int RECOVERY_CYCLES = nv_rtc_pkg::RECOVERY_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic select_b_i,
  input wire logic secondary_select_i,
  input wire logic oe_b_i,
  input wire logic we_b_i,
  input wire logic [12:0] address_lines_i,
  input wire logic [7:0] data_bus_i,
  output logic [7:0] data_bus_o,
  output logic data_bus_oe_b_o,
  input wire logic power_ok_i,
  input wire logic battery_low_i,
  output logic por_b_o
);
  // ==========================================================
  // Pin synchronisers
  nv_rtc_pkg::bus_pins_t pins_raw;
  nv_rtc_pkg::bus_pins_t pins;
  logic [1:0] status_s;
  logic pwr_ok;
  logic batt_low;

  assign pins_raw.sel_b = select_b_i;
  assign pins_raw.sec_sel = secondary_select_i;
  assign pins_raw.oe_b = oe_b_i;
  assign pins_raw.we_b = we_b_i;
  assign pins_raw.addr = address_lines_i;
  assign pins_raw.data = data_bus_i;

  pin_sync #(
    .W($bits(nv_rtc_pkg::bus_pins_t)),
    .INIT(nv_rtc_pkg::BUS_IDLE)
  ) u_bus_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i(pins_raw),
    .q_o(pins)
  );

  pin_sync #(
    .W(2),
    .INIT(nv_rtc_pkg::STATUS_RESET)
  ) u_status_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .d_i({power_ok_i, battery_low_i}),
    .q_o(status_s)
  );

  assign pwr_ok = status_s[1];
  assign batt_low = status_s[0];

  // ==========================================================
  // Power-fail deselect and recovery hold-off
  nv_rtc_pkg::pwr_state_t pwr_reg;
  nv_rtc_pkg::pwr_state_t pwr_next;
  logic [31:0] rec_cnt_reg;
  logic [31:0] rec_cnt_next;
  logic access_ok;

  always_comb begin
    pwr_next = pwr_reg;
    rec_cnt_next = 32'h00000000;
    unique case (pwr_reg)
      nv_rtc_pkg::PWR_DOWN: begin
        if (pwr_ok) begin
          pwr_next = nv_rtc_pkg::PWR_RECOVER;
        end
      end
      nv_rtc_pkg::PWR_RECOVER: begin
        // Any dip restarts the whole hold-off
        if (!pwr_ok) begin
          pwr_next = nv_rtc_pkg::PWR_DOWN;
        end else if (rec_cnt_reg == 32'(RECOVERY_CYCLES - 1)) begin
          pwr_next = nv_rtc_pkg::PWR_UP;
        end else begin
          rec_cnt_next = rec_cnt_reg + 32'h00000001;
        end
      end
      nv_rtc_pkg::PWR_UP: begin
        if (!pwr_ok) begin
          pwr_next = nv_rtc_pkg::PWR_DOWN;
        end
      end
      default: pwr_next = nv_rtc_pkg::PWR_DOWN;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      pwr_reg <= nv_rtc_pkg::PWR_DOWN;
      rec_cnt_reg <= 32'h00000000;
    end else begin
      pwr_reg <= pwr_next;
      rec_cnt_reg <= rec_cnt_next;
    end
  end

  assign access_ok = (pwr_reg == nv_rtc_pkg::PWR_UP);
  assign por_b_o = access_ok;

  // ==========================================================
  // Bus decode
  logic selected;
  logic rd_act;
  logic wr_act;
  logic clk_hit;
  logic [2:0] idx;

  assign selected = !pins.sel_b && pins.sec_sel && access_ok;
  assign rd_act = selected && !pins.oe_b && pins.we_b;
  assign wr_act = selected && !pins.we_b;
  assign clk_hit = pins.addr >= nv_rtc_pkg::CLK_REG_BASE;
  assign idx = pins.addr[2:0];

  // ==========================================================
  // Storage; not reset, it stands for nonvolatile memory
  logic [7:0] mem [nv_rtc_pkg::MEM_DEPTH];
  logic [7:0] mem_q;

  assign mem_q = mem[pins.addr];

  always_ff @(posedge clk_i) begin
    if (wr_act && !clk_hit) begin
      mem[pins.addr] <= pins.data;
    end
  end

  // ==========================================================
  // Timekeeping counters
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : v + 8'h01;
  endfunction

  function automatic logic [7:0] month_last(input logic [7:0] mon,
                                            input logic [7:0] yr);
    logic leap;
    leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                 : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 ||
                    yr[3:0] == 4'h8);
    unique case (mon)
      8'h02: month_last = leap ? 8'h29 : 8'h28;
      8'h04, 8'h06, 8'h09, 8'h11: month_last = 8'h30;
      default: month_last = 8'h31;
    endcase
  endfunction

  nv_rtc_pkg::cal_t cnt_reg;
  nv_rtc_pkg::cal_t cnt_next;
  nv_rtc_pkg::cal_t vis_reg;
  nv_rtc_pkg::cal_t vis_next;
  nv_rtc_pkg::cal_t inc;
  logic [31:0] tick_reg;
  logic [31:0] tick_next;
  logic tick;
  logic wr_flag_reg;
  logic rd_flag_reg;
  logic halt_reg;
  logic ftest_reg;
  logic wr_flag_next;
  logic rd_flag_next;
  logic halt_next;
  logic ftest_next;
  logic load_cnt;
  logic c_sec;
  logic c_min;
  logic c_hour;
  logic c_date;
  logic c_mon;
  logic c_year;

  // Oscillator stop freezes the prescaler, so no second is counted
  assign tick = !halt_reg && (tick_reg == 32'(TICK_CYCLES - 1));
  assign tick_next = halt_reg ? tick_reg
                   : (tick ? 32'h00000000 : tick_reg + 32'h00000001);

  assign c_sec = tick && (cnt_reg.seconds[6:0] == 7'h59);
  assign c_min = c_sec && (cnt_reg.minutes == 8'h59);
  assign c_hour = c_min && (cnt_reg.hours == 8'h23);
  assign c_date = c_hour &&
    (cnt_reg.date == month_last(cnt_reg.month, cnt_reg.year));
  assign c_mon = c_date && (cnt_reg.month == 8'h12);
  assign c_year = c_mon && (cnt_reg.year == 8'h99);

  always_comb begin
    inc = cnt_reg;
    if (tick) begin
      inc.seconds = c_sec ? 8'h00 : bcd_inc(cnt_reg.seconds);
    end
    if (c_sec) begin
      inc.minutes = c_min ? 8'h00 : bcd_inc(cnt_reg.minutes);
    end
    if (c_min) begin
      inc.hours = c_hour ? 8'h00 : bcd_inc(cnt_reg.hours);
    end
    if (c_hour) begin
      inc.day = (cnt_reg.day[2:0] == 3'h7) ? 8'h01 : cnt_reg.day + 8'h01;
      inc.date = c_date ? 8'h01 : bcd_inc(cnt_reg.date);
    end
    if (c_date) begin
      inc.month = c_mon ? 8'h01 : bcd_inc(cnt_reg.month);
    end
    if (c_mon) begin
      inc.year = c_year ? 8'h00 : bcd_inc(cnt_reg.year);
    end
    if (c_year) begin
      inc.century = bcd_inc(cnt_reg.century);
    end
  end

  // ==========================================================
  // Host side of the clock registers
  logic clk_wr;
  assign clk_wr = wr_act && clk_hit;

  always_comb begin
    wr_flag_next = wr_flag_reg;
    rd_flag_next = rd_flag_reg;
    halt_next = halt_reg;
    ftest_next = ftest_reg;
    if (clk_wr && idx == nv_rtc_pkg::IDX_CENTURY) begin
      wr_flag_next = pins.data[nv_rtc_pkg::WRITE_BIT];
      rd_flag_next = pins.data[nv_rtc_pkg::READ_BIT];
    end
    if (clk_wr && idx == nv_rtc_pkg::IDX_SECONDS) begin
      halt_next = pins.data[nv_rtc_pkg::CRYSTAL_HALT_BIT];
    end
    if (clk_wr && idx == nv_rtc_pkg::IDX_DAY) begin
      ftest_next = pins.data[nv_rtc_pkg::FREQ_TEST_BIT];
    end
  end

  // Falling write flag hands the loaded values to the counters
  assign load_cnt = wr_flag_reg && !wr_flag_next;

  always_comb begin
    vis_next = vis_reg;
    if (wr_flag_reg || rd_flag_reg) begin
      // Frozen for the host; only host writes change it
      if (clk_wr) begin
        vis_next[idx*8 +: 8] = pins.data;
      end
    end else begin
      // Refreshed every cycle, far inside the 500 us window
      vis_next = cnt_reg;
    end
    cnt_next = load_cnt ? vis_next : inc;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      cnt_reg <= nv_rtc_pkg::CAL_RESET;
      vis_reg <= nv_rtc_pkg::CAL_RESET;
      tick_reg <= 32'h00000000;
      wr_flag_reg <= 1'b0;
      rd_flag_reg <= 1'b0;
      halt_reg <= 1'b0;
      ftest_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      vis_reg <= vis_next;
      tick_reg <= tick_next;
      wr_flag_reg <= wr_flag_next;
      rd_flag_reg <= rd_flag_next;
      halt_reg <= halt_next;
      ftest_reg <= ftest_next;
    end
  end

  // ==========================================================
  // Read data path
  logic [7:0] clk_byte;
  logic [7:0] clk_q;
  logic [7:0] rd_data_next;
  logic [7:0] rd_data_reg;

  assign clk_byte = vis_reg[idx*8 +: 8];
  assign clk_q =
    (idx == nv_rtc_pkg::IDX_CENTURY) ?
      {wr_flag_reg, rd_flag_reg, clk_byte[5:0]} :
    (idx == nv_rtc_pkg::IDX_SECONDS) ? {halt_reg, clk_byte[6:0]} :
    (idx == nv_rtc_pkg::IDX_DAY) ?
      {batt_low, ftest_reg, clk_byte[5:0]} : clk_byte;
  // One output flop for both sources, so the pins see no select skew
  assign rd_data_next = clk_hit ? clk_q : mem_q;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      rd_data_reg <= 8'h00;
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  // Data answers one cycle after the synced address settles
  assign data_bus_o = rd_data_reg;
  assign data_bus_oe_b_o = !rd_act;
endmodule // nv_timekeeping_sram
`default_nettype wire

// file: hw/unused_placeholder_none.sv
`default_nettype none
`default_nettype wire

// file: verif/nv_rtc_properties.sv
`default_nettype none
module nv_rtc_checker #(
  parameter int RECOVERY_CYCLES = 8
) (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic select_b_i,
  input wire logic secondary_select_i,
  input wire logic oe_b_i,
  input wire logic we_b_i,
  input wire logic power_ok_i,
  input wire logic data_bus_oe_b_o,
  input wire logic por_b_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Saturates so a long powered run never wraps
  int up_cnt;
  wire logic pick = !select_b_i && secondary_select_i;
  wire logic rd = pick && !oe_b_i && we_b_i;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !power_ok_i) begin
      up_cnt <= 0;
    end else if (up_cnt < RECOVERY_CYCLES + 16) begin
      up_cnt <= up_cnt + 1;
    end
  end
  // ==========================================================
  // Properties
  sequence s_rd;
    (rd && por_b_o)[*8];
  endsequence
  sequence s_wr;
    (pick && !we_b_i)[*8];
  endsequence
  property p_blocked;
    !por_b_o |-> data_bus_oe_b_o;
  endproperty
  property p_fail;
    (!power_ok_i)[*8] |-> !por_b_o;
  endproperty
  property p_rec_min;
    $rose(por_b_o) |-> up_cnt >= RECOVERY_CYCLES;
  endproperty
  property p_rec_max;
    up_cnt >= RECOVERY_CYCLES + 12 |-> por_b_o;
  endproperty
  property p_por_hold;
    power_ok_i[*8] ##0 por_b_o |=> por_b_o;
  endproperty
  property p_read;
    s_rd |-> !data_bus_oe_b_o;
  endproperty
  property p_write;
    s_wr |-> data_bus_oe_b_o;
  endproperty
  property p_desel;
    (select_b_i || !secondary_select_i)[*8] |-> data_bus_oe_b_o;
  endproperty
  property p_oe_off;
    oe_b_i[*8] |-> data_bus_oe_b_o;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("drive while blocked");
  a_fail: assert property (p_fail)
    else $error("access open in power fail");
  a_rec_min: assert property (p_rec_min)
    else $error("recovery too short");
  a_rec_max: assert property (p_rec_max)
    else $error("recovery too long");
  a_por_hold: assert property (p_por_hold)
    else $error("reset out dropped");
  a_read: assert property (p_read)
    else $error("read not driven");
  a_write: assert property (p_write)
    else $error("driven during write");
  a_desel: assert property (p_desel)
    else $error("driven while deselected");
  a_oe_off: assert property (p_oe_off)
    else $error("driven with output off");
endmodule // nv_rtc_checker

bind nv_timekeeping_sram nv_rtc_checker #(
  .RECOVERY_CYCLES(RECOVERY_CYCLES)
) chk_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .select_b_i(select_b_i),
  .secondary_select_i(secondary_select_i), .oe_b_i(oe_b_i),
  .we_b_i(we_b_i), .power_ok_i(power_ok_i),
  .data_bus_oe_b_o(data_bus_oe_b_o), .por_b_o(por_b_o));
`default_nettype wire

// file: verif/host_bus_model.sv
`default_nettype none
// Each phase is held past the device's pin synchronisers
module host_bus_model (
  input wire logic clk_i,
  input wire logic [7:0] rd_data_i,
  input wire logic rd_oe_b_i,
  output var nv_rtc_pkg::bus_pins_t pins_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PH = 6;
  initial pins_o = nv_rtc_pkg::BUS_IDLE;
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Released lines show inverted values, never the last byte
  task automatic drop(input logic [12:0] a, input logic [7:0] d);
    pins_o <= '{sel_b: 1'b1, sec_sel: 1'b0, oe_b: 1'b1, we_b: 1'b1,
      addr: ~a, data: ~d};
    idle(PH);
  endtask
  task automatic wr_byte(input logic [12:0] a, input logic [7:0] d);
    @(posedge clk_i);
    pins_o <= '{sel_b: 1'b0, sec_sel: 1'b1, oe_b: 1'b1, we_b: 1'b1,
      addr: a, data: d};
    idle(PH);
    pins_o.we_b <= 1'b0;
    idle(PH + 2);
    pins_o.we_b <= 1'b1;
    idle(PH);
    drop(a, d);
  endtask
  task automatic rd_byte(input logic [12:0] a, output logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    pins_o <= '{sel_b: 1'b0, sec_sel: 1'b1, oe_b: 1'b0, we_b: 1'b1,
      addr: a, data: ~pins_o.data};
    while (rd_oe_b_i !== 1'b0 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    idle(PH);
    d = (n < 20) ? rd_data_i : 8'hXX;
    drop(a, d);
  endtask
endmodule // host_bus_model
`default_nettype wire

// file: verif/tb.sv
`default_nettype none
`define CHK(nm, e, g) \
  begin \
    checked++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("unexpected %s expected %h seen %h", nm, e, g); \
    end \
  end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TK = 1000;
  localparam int REC = 40;
  localparam logic [12:0] CEN = 13'h1FF8;
  localparam logic [12:0] SEC = 13'h1FF9;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic pwr = 1'b1;
  logic bat = 1'b1;
  nv_rtc_pkg::bus_pins_t pins;
  logic [7:0] dout;
  logic oe_b;
  logic por_b;
  int bad_count = 0;
  int checked = 0;
  int cyc = 0;
  int n;
  logic [7:0] s1;
  logic [7:0] s2;
  logic [7:0] yr [3] = '{8'h24, 8'h23, 8'h00};
  logic [7:0] dt [3] = '{8'h29, 8'h01, 8'h29};
  logic [7:0] mo [3] = '{8'h02, 8'h03, 8'h02};
  // Month, date, day with frequency test, hours, minutes, halted seconds
  logic [7:0] tv [6] = '{8'h02, 8'h28, 8'h47, 8'h23, 8'h59, 8'hD9};
  always #10 clk = ~clk;
  host_bus_model host_u (.clk_i(clk), .rd_data_i(dout),
    .rd_oe_b_i(oe_b), .pins_o(pins));
  nv_timekeeping_sram #(.TICK_CYCLES(TK), .RECOVERY_CYCLES(REC)) dut_u (
    .clk_i(clk), .rst_b_i(rst_b), .select_b_i(pins.sel_b),
    .secondary_select_i(pins.sec_sel), .oe_b_i(pins.oe_b),
    .we_b_i(pins.we_b), .address_lines_i(pins.addr),
    .data_bus_i(pins.data), .data_bus_o(dout),
    .data_bus_oe_b_o(oe_b), .power_ok_i(pwr),
    .battery_low_i(bat), .por_b_o(por_b));
  task automatic rc(input logic [12:0] a, input logic [7:0] e,
    input string nm);
    logic [7:0] d;
    host_u.rd_byte(a, d);
    `CHK(nm, e, d)
  endtask
  task automatic wait_por();
    n = 0;
    while (por_b !== 1'b1 && n < 500) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatched %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      bad_count++;
      end_of_test();
    end
  end
  initial begin
    // Reset loads the synchronisers, so three edges are enough
    repeat (3) @(posedge clk);
    `CHK("por in reset", 1'b0, por_b)
    rst_b <= 1'b1;
    wait_por();
    `CHK("recovery", 1'b1, n >= REC && n <= REC + 10)
    host_u.wr_byte(13'h0000, 8'hAA);
    host_u.wr_byte(13'h1FF7, 8'h5C);
    rc(13'h0000, 8'hAA, "mem low");
    rc(13'h1FF7, 8'h5C, "mem top");
    rc(CEN, 8'h20, "century");
    for (int i = 0; i < 3; i++) begin
      host_u.wr_byte(CEN, 8'hA0);
      host_u.wr_byte(13'h1FFF, yr[i]);
      for (int j = 0; j < 6; j++) begin
        host_u.wr_byte(13'h1FFE - 13'(j), tv[j]);
      end
      host_u.wr_byte(CEN, 8'h20);
      repeat (3 * TK) @(posedge clk);
      rc(SEC, 8'hD9, "halted sec");
      host_u.wr_byte(CEN, 8'hA0);
      host_u.wr_byte(SEC, 8'h59);
      host_u.wr_byte(CEN, 8'h20);
      repeat (TK + 50) @(posedge clk);
      host_u.wr_byte(CEN, 8'h60);
      rc(13'h1FFD, dt[i], "date");
      rc(13'h1FFE, mo[i], "month");
      rc(13'h1FFB, 8'h00, "hours");
      rc(13'h1FFC, 8'hC1, "day");
    end
    host_u.rd_byte(SEC, s1);
    // One or two seconds pass between loading 23:59:59 and the freeze
    `CHK("sec at freeze", 1'b1, s1 <= 8'h01)
    repeat (3 * TK) @(posedge clk);
    rc(SEC, s1, "frozen sec");
    host_u.wr_byte(CEN, 8'h20);
    repeat (nv_rtc_pkg::READ_HALT_MIN_CYCLES) @(posedge clk);
    host_u.rd_byte(SEC, s2);
    // At least 28 seconds elapse, counted through the freeze as well
    `CHK("sec advance", 1'b1, s2 >= s1 + 8'h28)
    bat <= 1'b0;
    rc(13'h1FFC, 8'h41, "battery ok");
    pwr <= 1'b0;
    repeat (10) @(posedge clk);
    `CHK("por low", 1'b0, por_b)
    host_u.wr_byte(13'h0000, 8'h33);
    pwr <= 1'b1;
    wait_por();
    `CHK("recovery", 1'b1, n >= REC && n <= REC + 10)
    rc(13'h0000, 8'hAA, "blocked write");
    end_of_test();
  end
endmodule // tb
`default_nettype wire
